// file: lnk_pkg.sv
`default_nettype none
package lnk_pkg;
   // bus register byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'h00;   // read: block state
   localparam logic [7:0] ADDR_CONTROL = 8'h04;  // read/write: enables
   localparam logic [7:0] ADDR_TXQ_FIRST = 8'h80; // queue write, packet continues
   localparam logic [7:0] ADDR_TXQ_LAST = 8'h8c;  // queue write, ends the packet
   // control fields
   localparam int CTL_TX_EN_BIT = 0;     // enables the transmit queue path
   localparam int CTL_SID_EN_BIT = 1;    // enables self-id packet assembly
   localparam logic [1:0] CTL_RESET = 2'h3;
   // status fields
   localparam int STS_TX_FULL_BIT = 0;   // holding quadlet waits for the phy
   localparam int STS_SID_BUSY_BIT = 1;  // self-id packet under assembly
   localparam int STS_FIRST_BIT = 2;     // next queue write is a first quadlet
   // link-on marker and its patch
   localparam logic [15:0] LINKON_MARK = 16'h00e0;
   localparam int MARK_NIB_LSB = 4;       // position of the eh nibble
   localparam logic [3:0] MARK_NIB_PATCH = 4'h0;
   // self-id header and status layout
   localparam logic [3:0] TCODE_SELFID = 4'he;
   localparam int HDR_TCODE_LSB = 4;
   localparam int HDR_PRI_LSB = 0;
   localparam int STAT_SPD_LSB = 16;
   localparam int STAT_ACK_LSB = 0;
   // speed codes
   localparam logic [1:0] SPD_100 = 2'h0;
   localparam logic [1:0] SPD_200 = 2'h1;
   localparam logic [1:0] SPD_400 = 2'h2;
   localparam logic [1:0] SPD_UNDEF = 2'h3;
   // self-id assembly states
   typedef enum logic [1:0] {
      SID_IDLE = 2'b00,
      SID_HEAD = 2'b01,
      SID_DATA = 2'b10,
      SID_STAT = 2'b11
   } lnk_sid_state_e;
endpackage : lnk_pkg
`default_nettype wire

// file: lnk_framer.sv
// Overview of operation
// R01: host writes link-on first quadlet at 80h
// R02: host writes final quadlet at 8ch
// R03: low half-word 00e0h marks link-on packet
// R04: marker eh nibble becomes 0h toward phy
// R05: host sets identifier 01 in top bits
// R06: host fills target_node_field with target id
// R07: host writes complemented upper half, ones below
// R08: self-id header carries transaction code eh
// R09: self-id quadlets follow in arrival order
// R10: one status quadlet ends the packet
// R11: speed code 00/01/10, 11 undefined
// R12: status carries the returned_acknowledge code
// R13: header carries the packet priority field
// R14: self-id packet never interleaved with others
`timescale 1ns/1ns
`default_nettype none
module lnk_framer (
   input wire logic i_mclk,               // 25 mhz host clock
   input wire logic i_rstn,               // async reset, active low
   input wire logic i_hsel,               // ahb-lite slave select
   input wire logic [31:0] i_haddr,       // ahb address
   input wire logic [1:0] i_htrans,       // ahb transfer type
   input wire logic i_hwrite,             // ahb write
   input wire logic [2:0] i_hsize,        // ahb size, word only
   input wire logic [31:0] i_hwdata,      // ahb write data
   input wire logic i_hready,             // ahb bus ready
   output logic o_hreadyout,              // ahb slave ready
   output logic o_hresp,                  // ahb response, always okay
   output logic [31:0] o_hrdata,          // ahb read data
   output logic o_phy_valid,              // quadlet toward phy valid
   output logic [31:0] o_phy_data,        // quadlet toward phy
   output logic o_phy_last,               // last quadlet of packet
   input wire logic i_phy_ready,          // phy takes the quadlet
   input wire logic i_sid_valid,          // received self-id quadlet valid
   input wire logic [31:0] i_sid_data,    // received self-id quadlet
   input wire logic i_sid_last,           // final self-id quadlet of phase
   input wire logic [3:0] i_sid_pri,      // priority of the self-id packet
   input wire logic [1:0] i_sid_spd,      // receive speed, with last
   input wire logic [3:0] i_sid_ack,      // returned_acknowledge, with last
   output logic o_sid_ready,              // self-id quadlet taken
   input wire logic i_pkt_valid,          // other received packet quadlet
   input wire logic [31:0] i_pkt_data,    // other packet quadlet
   input wire logic i_pkt_last,           // other packet end
   output logic o_pkt_ready,              // other packet quadlet taken
   output logic o_grf_valid,              // receive fifo write valid
   output logic [31:0] o_grf_data,        // receive fifo write data
   output logic o_grf_last,               // receive fifo packet end
   input wire logic i_grf_ready           // receive fifo accepts
);
   logic dp_act;                 // data phase pending
   logic dp_write;               // data phase is a write
   logic [7:0] dp_addr;          // latched address
   logic [1:0] ctl;              // control register
   logic first_q;                // next queue write starts a packet
   logic wr_txq;                 // queue write in this data phase
   logic wr_done;                // bus write completes now
   logic next_first_q;           // first flag after this write
   logic [31:0] tx_word;         // queue word after marker patch
   lnk_pkg::lnk_sid_state_e sid_state; // self-id assembly state
   logic pkt_lock;               // other packet in progress
   logic out_load;               // output stage may load
   logic [3:0] pri_q;            // captured priority
   logic [1:0] spd_q;            // captured speed
   logic [3:0] ack_q;            // captured acknowledge

   // address phase capture, word transfers only
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         dp_act <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else if (i_hready) begin
         // only whole-word transfers are taken; narrower sizes are ignored
         dp_act <= i_hsel && i_htrans[1] && (i_hsize == 3'h2);
         dp_write <= i_hwrite;
         dp_addr <= i_haddr[7:0];
      end
   end

   // queue writes wait while the holding quadlet is still with the phy
   assign wr_txq = dp_act && dp_write &&
      (dp_addr == lnk_pkg::ADDR_TXQ_FIRST || dp_addr == lnk_pkg::ADDR_TXQ_LAST);
   assign o_hreadyout = !(wr_txq && o_phy_valid);
   assign o_hresp = 1'b0;
   assign wr_done = dp_act && dp_write && o_hreadyout;

   // read mux: unmapped and queue addresses read zero
   always_comb begin
      o_hrdata = 32'h0000_0000;
      if (dp_act && !dp_write) begin
         case (dp_addr)
            lnk_pkg::ADDR_STATUS: begin
               o_hrdata[lnk_pkg::STS_TX_FULL_BIT] = o_phy_valid;
               o_hrdata[lnk_pkg::STS_SID_BUSY_BIT] = (sid_state != lnk_pkg::SID_IDLE);
               o_hrdata[lnk_pkg::STS_FIRST_BIT] = first_q;
            end
            lnk_pkg::ADDR_CONTROL: begin
               o_hrdata[1:0] = ctl;
            end
            default: begin
               o_hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // control register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctl <= lnk_pkg::CTL_RESET;
      end else if (wr_done && dp_addr == lnk_pkg::ADDR_CONTROL) begin
         ctl <= i_hwdata[1:0];
      end
   end

   // marker check and patch on the first quadlet only
   always_comb begin
      tx_word = i_hwdata;
      if (first_q && i_hwdata[15:0] == lnk_pkg::LINKON_MARK) begin // see R03
         tx_word[lnk_pkg::MARK_NIB_LSB +: 4] = lnk_pkg::MARK_NIB_PATCH; // see R04
      end
      next_first_q = (dp_addr == lnk_pkg::ADDR_TXQ_LAST); // see R02
   end

   // first-quadlet tracking; 80h continues, 8ch ends a packet
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         first_q <= 1'b1;
      end else if (wr_done && wr_txq && ctl[lnk_pkg::CTL_TX_EN_BIT]) begin // see R01
         first_q <= next_first_q;
      end
   end

   // holding quadlet toward the phy
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_phy_valid <= 1'b0;
         o_phy_data <= 32'h0000_0000;
         o_phy_last <= 1'b0;
      end else if (wr_done && wr_txq && ctl[lnk_pkg::CTL_TX_EN_BIT]) begin
         o_phy_valid <= 1'b1;
         o_phy_data <= tx_word;
         o_phy_last <= next_first_q;
      end else if (i_phy_ready) begin
         o_phy_valid <= 1'b0;
      end
   end

   // output stage toward the receive fifo
   assign out_load = !o_grf_valid || i_grf_ready;
   assign o_sid_ready = (sid_state == lnk_pkg::SID_DATA) && out_load;
   // other packets only move while no self-id packet is open
   assign o_pkt_ready = (sid_state == lnk_pkg::SID_IDLE) && out_load; // see R14

   // other-packet lock: a self-id packet waits for its end
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         pkt_lock <= 1'b0;
      end else if (i_pkt_valid && o_pkt_ready) begin
         pkt_lock <= !i_pkt_last;
      end
   end

   // self-id assembly: header, data, status
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         sid_state <= lnk_pkg::SID_IDLE;
         pri_q <= 4'h0;
         spd_q <= 2'h0;
         ack_q <= 4'h0;
      end else begin
         case (sid_state)
            lnk_pkg::SID_IDLE: begin
               // start only between other packets, see R14
               if (i_sid_valid && ctl[lnk_pkg::CTL_SID_EN_BIT] && !pkt_lock &&
                   !(i_pkt_valid && o_pkt_ready)) begin
                  sid_state <= lnk_pkg::SID_HEAD;
                  pri_q <= i_sid_pri;
               end
            end
            lnk_pkg::SID_HEAD: begin
               if (out_load) begin
                  sid_state <= lnk_pkg::SID_DATA;
               end
            end
            lnk_pkg::SID_DATA: begin
               if (i_sid_valid && o_sid_ready && i_sid_last) begin
                  sid_state <= lnk_pkg::SID_STAT;
                  spd_q <= i_sid_spd;
                  ack_q <= i_sid_ack;
               end
            end
            lnk_pkg::SID_STAT: begin
               if (out_load) begin
                  sid_state <= lnk_pkg::SID_IDLE;
               end
            end
            default: begin
               sid_state <= lnk_pkg::SID_IDLE;
            end
         endcase
      end
   end

   // receive fifo write register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_grf_valid <= 1'b0;
         o_grf_data <= 32'h0000_0000;
         o_grf_last <= 1'b0;
      end else if (out_load) begin
         o_grf_valid <= 1'b0;
         o_grf_last <= 1'b0;
         if (sid_state == lnk_pkg::SID_HEAD) begin
            o_grf_valid <= 1'b1;
            o_grf_data <= 32'h0000_0000;
            o_grf_data[lnk_pkg::HDR_TCODE_LSB +: 4] <= lnk_pkg::TCODE_SELFID; // see R08
            o_grf_data[lnk_pkg::HDR_PRI_LSB +: 4] <= pri_q; // see R13
         end else if (sid_state == lnk_pkg::SID_DATA && i_sid_valid) begin
            o_grf_valid <= 1'b1;
            o_grf_data <= i_sid_data; // see R09
         end else if (sid_state == lnk_pkg::SID_STAT) begin
            o_grf_valid <= 1'b1;
            o_grf_last <= 1'b1; // see R10
            o_grf_data <= 32'h0000_0000;
            o_grf_data[lnk_pkg::STAT_SPD_LSB +: 2] <= spd_q; // see R11
            o_grf_data[lnk_pkg::STAT_ACK_LSB +: 4] <= ack_q; // see R12
         end else if (sid_state == lnk_pkg::SID_IDLE && i_pkt_valid) begin
            o_grf_valid <= 1'b1;
            o_grf_data <= i_pkt_data;
            o_grf_last <= i_pkt_last;
         end
      end
   end

   AST_LINKON_PATCH: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R04
      wr_done && wr_txq && ctl[0] && first_q && i_hwdata[15:0] == 16'h00e0
      |=> o_phy_valid && o_phy_data[15:0] == 16'h0000)
      else $error("link-on marker not patched");
   AST_PLAIN_PASS: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R03
      wr_done && wr_txq && ctl[0] && i_hwdata[15:0] != 16'h00e0
      |=> o_phy_data == $past(i_hwdata))
      else $error("ordinary quadlet altered");
   AST_LAST_MARK: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R02
      wr_done && wr_txq && ctl[0] |=> o_phy_last == ($past(dp_addr) == 8'h8c) &&
      first_q == o_phy_last)
      else $error("packet end mark wrong");
   AST_TX_STALL: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R01
      o_phy_valid && !i_phy_ready |=> o_phy_valid && $stable(o_phy_data) &&
      $stable(o_phy_last))
      else $error("queue write overran holding quadlet");
   AST_HEAD: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R08
      sid_state == lnk_pkg::SID_HEAD && out_load
      |=> o_grf_valid && o_grf_data[7:4] == 4'he && sid_state == lnk_pkg::SID_DATA)
      else $error("self-id header wrong");
   AST_HEAD_PRI: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R13
      sid_state == lnk_pkg::SID_IDLE ##1 sid_state == lnk_pkg::SID_HEAD && out_load
      |=> o_grf_data[3:0] == $past(i_sid_pri, 2))
      else $error("header priority wrong");
   AST_SID_DATA: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R09
      i_sid_valid && o_sid_ready |=> o_grf_valid && o_grf_data == $past(i_sid_data))
      else $error("self-id quadlet lost or reordered");
   AST_STATUS: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R11
      i_sid_valid && o_sid_ready && i_sid_last ##1 out_load
      |=> o_grf_last && o_grf_data[17:16] == $past(i_sid_spd, 2) &&
      o_grf_data[3:0] == $past(i_sid_ack, 2))
      else $error("status quadlet wrong");
   AST_NO_MIX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // see R14
      sid_state != lnk_pkg::SID_IDLE |-> !o_pkt_ready ##0 !(pkt_lock && $rose(sid_state[0])))
      else $error("other packet mixed into self-id packet");
endmodule : lnk_framer
`default_nettype wire

// file: lnk_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: phy sink and receive fifo; each stalls one cycle in four
module lnk_far_model (
   input wire logic i_mclk,            // host clock
   input wire logic i_rstn,            // async reset, active low
   input wire logic i_phy_valid,       // quadlet offered to phy
   input wire logic [31:0] i_phy_data, // quadlet toward phy
   input wire logic i_phy_last,        // packet end toward phy
   output logic o_phy_ready,           // phy takes the quadlet
   input wire logic i_grf_valid,       // receive fifo write
   input wire logic [31:0] i_grf_data, // receive fifo data
   input wire logic i_grf_last,        // receive fifo packet end
   output logic o_grf_ready            // receive fifo accepts
);
   logic [1:0] stall_cnt; // free-running stall pattern
   logic [32:0] phy_q[$]; // {last, quadlet} taken by phy
   logic [32:0] grf_q[$]; // {last, quadlet} taken by fifo
   // counter drives the stall pattern so holding stages are exercised
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         stall_cnt <= 2'h0;
      end else begin
         stall_cnt <= stall_cnt + 2'h1;
      end
   end
   assign o_phy_ready = (stall_cnt != 2'h3);
   assign o_grf_ready = (stall_cnt != 2'h1);
   // record every quadlet at the edge that takes it
   always @(posedge i_mclk) begin
      if (i_rstn && i_phy_valid && o_phy_ready) begin
         phy_q.push_back({i_phy_last, i_phy_data});
      end
      if (i_rstn && i_grf_valid && o_grf_ready) begin
         grf_q.push_back({i_grf_last, i_grf_data});
      end
   end
endmodule : lnk_far_model
`default_nettype wire

// file: lnk_framer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module lnk_framer_tb_top;
   logic i_mclk, i_rstn, hsel, hwrite, sid_valid, sid_last;
   logic [31:0] haddr, hwdata, sid_data, rd;
   logic [1:0] htrans, sid_spd;
   logic [3:0] sid_pri, sid_ack;
   logic hreadyout, hresp, phy_valid, phy_last, phy_ready, sid_ready, grf_valid, grf_last;
   logic grf_ready;
   logic pkt_valid, pkt_last, pkt_ready; // other received packet stream
   logic [31:0] pkt_data;
   logic [31:0] hrdata, phy_data, grf_data;
   logic [32:0] exp_phy[$]; // expected {last, quadlet} at phy
   logic [32:0] exp_grf[$]; // expected {last, quadlet} at fifo
   int bad_count, num_checks;
   lnk_framer dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
      .o_phy_valid(phy_valid), .o_phy_data(phy_data), .o_phy_last(phy_last),
      .i_phy_ready(phy_ready), .i_sid_valid(sid_valid), .i_sid_data(sid_data),
      .i_sid_last(sid_last), .i_sid_pri(sid_pri), .i_sid_spd(sid_spd), .i_sid_ack(sid_ack),
      .o_sid_ready(sid_ready), .i_pkt_valid(pkt_valid), .i_pkt_data(pkt_data),
      .i_pkt_last(pkt_last), .o_pkt_ready(pkt_ready),
      .o_grf_valid(grf_valid), .o_grf_data(grf_data),
      .o_grf_last(grf_last), .i_grf_ready(grf_ready));
   lnk_far_model far_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_phy_valid(phy_valid),
      .i_phy_data(phy_data), .i_phy_last(phy_last), .o_phy_ready(phy_ready),
      .i_grf_valid(grf_valid), .i_grf_data(grf_data), .i_grf_last(grf_last),
      .o_grf_ready(grf_ready));
   // 25 mhz clock
   always #20 i_mclk = ~i_mclk;
   // counts one comparison and reports a mismatch
   task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // one ahb-lite single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge i_mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // offers one self-id quadlet and holds it until taken
   task automatic sid(input logic [31:0] d, input logic l, input logic [1:0] s,
                      input logic [3:0] k);
      sid_valid <= 1'b1;
      sid_data <= d;
      sid_last <= l;
      sid_spd <= s;
      sid_ack <= k;
      do @(posedge i_mclk); while (sid_ready !== 1'b1);
   endtask : sid
   // offers one other received quadlet and holds it until taken
   task automatic pkt(input logic [31:0] d, input logic l);
      pkt_valid <= 1'b1;
      pkt_data <= d;
      pkt_last <= l;
      do @(posedge i_mclk); while (pkt_ready !== 1'b1);
   endtask : pkt
   // prints counts and verdict, then stops
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge i_mclk);
      bad_count++;
      end_of_test();
   end
   // main sequence
   initial begin
      {i_mclk, i_rstn, hsel, hwrite, sid_valid, sid_last, sid_spd, sid_pri, sid_ack} = '0;
      {haddr, hwdata, sid_data, htrans} = '0;
      {pkt_valid, pkt_last, pkt_data} = '0;
      repeat (10) @(posedge i_mclk);
      i_rstn <= 1'b1;
      // reset values and an unmapped place
      ahb(1'b0, lnk_pkg::ADDR_STATUS, 32'h0);
      check("status", 33'h4, {1'b0, rd});
      ahb(1'b0, lnk_pkg::ADDR_CONTROL, 32'h0);
      check("control", 33'h3, {1'b0, rd});
      ahb(1'b1, 8'h10, 32'hffffffff);
      ahb(1'b0, 8'h10, 32'h0);
      check("unmapped", 33'h0, {1'b0, rd});
      // link-on pair, a status read between them; the phy takes each quadlet at an edge where its ready is high
      ahb(1'b1, lnk_pkg::ADDR_TXQ_FIRST, 32'h4a0000e0);
      exp_phy.push_back({1'b0, 32'h4a000000});
      ahb(1'b0, lnk_pkg::ADDR_STATUS, 32'h0);
      check("status first", 33'h0, {32'h0, rd[lnk_pkg::STS_FIRST_BIT]});
      ahb(1'b1, lnk_pkg::ADDR_TXQ_LAST, 32'hb5ffffff);
      exp_phy.push_back({1'b1, 32'hb5ffffff});
      // ordinary packet whose low half-word only resembles the marker
      ahb(1'b1, lnk_pkg::ADDR_TXQ_FIRST, 32'h7fff12e0);
      exp_phy.push_back({1'b0, 32'h7fff12e0});
      ahb(1'b1, lnk_pkg::ADDR_TXQ_LAST, 32'h8000ffff);
      exp_phy.push_back({1'b1, 32'h8000ffff});
      // queue writes with transmit disabled are dropped
      ahb(1'b1, lnk_pkg::ADDR_CONTROL, 32'h2);
      ahb(1'b1, lnk_pkg::ADDR_TXQ_FIRST, 32'h4a0000e0);
      ahb(1'b1, lnk_pkg::ADDR_CONTROL, 32'h3);
      // self-id packets, one for each speed code
      for (int s = 0; s < 4; s++) begin
         sid_pri <= 4'(s + 5);
         exp_grf.push_back({1'b0, 24'h0, lnk_pkg::TCODE_SELFID, 4'(s + 5)});
         for (int k = 0; k < 2; k++) begin
            sid(32'h51000000 + 32'(s * 16 + k), k == 1, 2'(s), 4'(s + 1));
            exp_grf.push_back({1'b0, 32'h51000000 + 32'(s * 16 + k)});
         end
         exp_grf.push_back({1'b1, 14'h0, 2'(s), 12'h0, 4'(s + 1)});
      end
      sid_valid <= 1'b0;
      // other packet open: self-id offered meanwhile must wait for its end
      pkt(32'h0a0b0c0d, 1'b0);
      exp_grf.push_back({1'b0, 32'h0a0b0c0d});
      sid_pri <= 4'h2;
      sid_valid <= 1'b1;
      sid_data <= 32'h52000000;
      sid_last <= 1'b1;
      pkt(32'h0e0f1011, 1'b1);
      exp_grf.push_back({1'b1, 32'h0e0f1011});
      pkt_valid <= 1'b0;
      exp_grf.push_back({1'b0, 24'h0, lnk_pkg::TCODE_SELFID, 4'h2});
      sid(32'h52000000, 1'b1, lnk_pkg::SPD_400, 4'h1);
      exp_grf.push_back({1'b0, 32'h52000000});
      exp_grf.push_back({1'b1, 14'h0, lnk_pkg::SPD_400, 12'h0, 4'h1});
      sid_valid <= 1'b0;
      for (int i = 0; i < 300 && far_u.grf_q.size() < exp_grf.size(); i++) @(posedge i_mclk);
      check("phy count", 33'(exp_phy.size()), 33'(far_u.phy_q.size()));
      check("fifo count", 33'(exp_grf.size()), 33'(far_u.grf_q.size()));
      foreach (exp_phy[i]) check("phy quadlet", exp_phy[i], far_u.phy_q[i]);
      foreach (exp_grf[i]) check("fifo quadlet", exp_grf[i], far_u.grf_q[i]);
      end_of_test();
   end
endmodule : lnk_framer_tb_top
`default_nettype wire
